// file: inc/isf_pkg.sv
package isf_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
    localparam logic [7:0] OFS_TXDATA = 8'h10;
    localparam logic [7:0] OFS_OPRES = 8'h14;
    // Control register fields
    localparam int CTRL_DMA_BIT = 0;
    localparam int CTRL_BLEN_LSB = 4;
    localparam int CTRL_THR_LSB = 8;
    localparam int FIELD_W = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0ff1;
    // Interrupt status bits
    localparam int IRQ_W = 6;
    localparam int IRQ_TX_LOW = 0;
    localparam int IRQ_RD_REQ = 1;
    localparam int IRQ_RD_EMPTY = 2;
    localparam int IRQ_TGT_DONE = 3;
    localparam int IRQ_OP_DONE = 4;
    localparam int IRQ_OP_ABORT = 5;
    // Operation result layout
    localparam int KIND_LSB = 0;
    localparam int PROG_LSB = 2;
    localparam int CAUSE_LSB = 4;
    localparam logic [1:0] KIND_CONTROLLER_WRITE = 2'h0;
    localparam logic [1:0] KIND_CONTROLLER_READ = 2'h1;
    localparam logic [1:0] KIND_TARGET_RECEIVE = 2'h2;
    localparam logic [1:0] KIND_TARGET_TRANSMIT = 2'h3;
    localparam logic [1:0] PROG_IDLE_CODE = 2'h0;
    localparam logic [1:0] PROG_IN_PROGRESS = 2'h1;
    localparam logic [1:0] PROG_OK = 2'h2;
    localparam logic [1:0] PROG_ABORT = 2'h3;
    localparam logic [2:0] CAUSE_ADDRESS_REFUSED = 3'h0;
    localparam logic [2:0] CAUSE_DATA_REFUSED = 3'h1;
    localparam logic [2:0] CAUSE_ARBITRATION_DEFEAT = 3'h3;
    localparam logic [2:0] CAUSE_MISPLACED_START_ERROR = 3'h4;
    localparam logic [2:0] CAUSE_MISPLACED_STOP_ERROR = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {D_IDLE, D_WAIT} isf_dma_e;
endpackage : isf_pkg

// file: rtl/isf_top.sv
`timescale 1ns/10ps
module isf_top #(
    parameter int DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic op_start,
    input wire logic [1:0] op_kind,
    input wire logic op_ok,
    input wire logic address_refused,
    input wire logic data_refused,
    input wire logic arbitration_defeat,
    input wire logic misplaced_start_error,
    input wire logic misplaced_stop_error,
    input wire logic tgt_read_req,
    input wire logic tgt_nack_end,
    input wire logic tx_take,
    input wire logic dma_served,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    output logic scl_hold_low,
    output logic dma_single_req,
    output logic dma_burst_req,
    output logic dma_last,
    output logic irq
);
    localparam int CNT_W = $clog2(DEPTH + 2);
    generate
        if (DEPTH > 15)
        begin : g_bad_depth
            $error("isf_top DEPTH above 15 exceeds the threshold field");
        end
    endgenerate

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : strb_merge

    function automatic logic [2:0] abort_cause(input logic st, input logic sp,
                                               input logic arb, input logic na);
        if (st)
            return isf_pkg::CAUSE_MISPLACED_START_ERROR;
        else if (sp)
            return isf_pkg::CAUSE_MISPLACED_STOP_ERROR;
        else if (arb)
            return isf_pkg::CAUSE_ARBITRATION_DEFEAT;
        else if (na)
            return isf_pkg::CAUSE_ADDRESS_REFUSED;
        else
            return isf_pkg::CAUSE_DATA_REFUSED;
    endfunction : abort_cause

    // Bus slave state
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_got_reg, w_got_reg;
    logic [7:0] waddr_reg, raddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic rd_pend_reg;
    // Block state
    logic [31:0] ctrl_reg;
    logic [isf_pkg::IRQ_W-1:0] stat_reg, en_reg, stat_next;
    logic irq_reg;
    logic [1:0] kind_reg, prog_reg;
    logic [2:0] cause_reg;
    logic flush_pend_reg, low_q_reg, empty_q_reg, final_pend_reg;
    logic scl_reg, single_reg, burst_reg, last_reg;
    isf_pkg::isf_dma_e dma_state_reg;

    // Write decode
    wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
    wire wr_ctrl = do_write && waddr_reg == isf_pkg::OFS_CTRL;
    wire wr_clr = do_write && waddr_reg == isf_pkg::OFS_IRQ_CLR;
    wire wr_en = do_write && waddr_reg == isf_pkg::OFS_IRQ_EN;
    wire wr_tx = do_write && waddr_reg == isf_pkg::OFS_TXDATA && wstrb_reg[0];
    wire wr_hit = waddr_reg == isf_pkg::OFS_CTRL || waddr_reg == isf_pkg::OFS_IRQ_STAT
                  || waddr_reg == isf_pkg::OFS_IRQ_CLR || waddr_reg == isf_pkg::OFS_IRQ_EN
                  || waddr_reg == isf_pkg::OFS_TXDATA || waddr_reg == isf_pkg::OFS_OPRES;
    wire [31:0] opres_word = {25'h0, cause_reg, prog_reg, kind_reg};
    wire rd_hit = raddr_reg == isf_pkg::OFS_CTRL || raddr_reg == isf_pkg::OFS_IRQ_STAT
                  || raddr_reg == isf_pkg::OFS_IRQ_CLR || raddr_reg == isf_pkg::OFS_IRQ_EN
                  || raddr_reg == isf_pkg::OFS_TXDATA || raddr_reg == isf_pkg::OFS_OPRES;
    wire [31:0] rd_word = raddr_reg == isf_pkg::OFS_CTRL ? ctrl_reg
                        : raddr_reg == isf_pkg::OFS_IRQ_STAT ? 32'(stat_reg)
                        : raddr_reg == isf_pkg::OFS_IRQ_EN ? 32'(en_reg)
                        : raddr_reg == isf_pkg::OFS_OPRES ? opres_word : 32'h0000_0000;

    // Control fields
    wire dma_mode = ctrl_reg[isf_pkg::CTRL_DMA_BIT];
    wire [CNT_W-1:0] blen = CNT_W'(ctrl_reg[isf_pkg::CTRL_BLEN_LSB +: isf_pkg::FIELD_W]);
    wire [CNT_W-1:0] thr = CNT_W'(ctrl_reg[isf_pkg::CTRL_THR_LSB +: isf_pkg::FIELD_W]);

    // Transmit FIFO
    logic fifo_wr_ready, fifo_valid;
    logic [7:0] fifo_data;
    logic [CNT_W-1:0] free_cnt;
    wire flush = tgt_read_req;
    isf_txfifo #(.WIDTH(8), .DEPTH(DEPTH), .CNT_W(CNT_W)) i_isf_txfifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(flush),
        .wr_valid(wr_tx),
        .wr_data(wdata_reg[7:0]),
        .wr_ready(fifo_wr_ready),
        .rd_ready(tx_take),
        .rd_valid(fifo_valid),
        .rd_data(fifo_data),
        .free_count(free_cnt)
    );

    // Operation tracking
    wire busy = prog_reg == isf_pkg::PROG_IN_PROGRESS;
    wire ctl_op = kind_reg == isf_pkg::KIND_CONTROLLER_WRITE
                  || kind_reg == isf_pkg::KIND_CONTROLLER_READ;
    wire tt_active = busy && kind_reg == isf_pkg::KIND_TARGET_TRANSMIT;
    wire ab_ctl = ctl_op && (address_refused || arbitration_defeat
                  || (data_refused && kind_reg == isf_pkg::KIND_CONTROLLER_WRITE));
    wire ab_any = busy && (misplaced_start_error || misplaced_stop_error || ab_ctl);
    wire tt_done = tt_active && tgt_nack_end && !ab_any;
    wire ok_ev = busy && !ab_any && (tt_done || (op_ok && !tt_active));
    wire low_lvl = !dma_mode && (CNT_W'(DEPTH) - free_cnt) <= thr;
    wire empty_lvl = tt_active && !fifo_valid;
    wire fill_room = free_cnt != '0;
    wire pick_burst = blen != '0 && free_cnt >= blen;
    wire dma_go = dma_mode && (final_pend_reg || tt_done || (tt_active && fill_room));

    // Event flags: set wins over clear
    always_comb
    begin
        stat_next = stat_reg & ~(wr_clr ? wdata_reg[isf_pkg::IRQ_W-1:0] : '0);
        stat_next[isf_pkg::IRQ_TX_LOW] = stat_next[isf_pkg::IRQ_TX_LOW]
                                         | (low_lvl && !low_q_reg);
        stat_next[isf_pkg::IRQ_RD_REQ] = stat_next[isf_pkg::IRQ_RD_REQ]
                                         | flush_pend_reg;
        stat_next[isf_pkg::IRQ_RD_EMPTY] = stat_next[isf_pkg::IRQ_RD_EMPTY]
                                           | (empty_lvl && !empty_q_reg);
        stat_next[isf_pkg::IRQ_TGT_DONE] = stat_next[isf_pkg::IRQ_TGT_DONE] | tt_done;
        stat_next[isf_pkg::IRQ_OP_DONE] = stat_next[isf_pkg::IRQ_OP_DONE] | ok_ev;
        stat_next[isf_pkg::IRQ_OP_ABORT] = stat_next[isf_pkg::IRQ_OP_ABORT] | ab_any;
    end

    // Bus write channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= isf_pkg::RESP_OKAY;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            awready_reg <= awvalid && !awready_reg && !aw_got_reg && !bvalid_reg;
            wready_reg <= wvalid && !wready_reg && !w_got_reg && !bvalid_reg;
            if (awvalid && awready_reg)
            begin
                aw_got_reg <= 1'b1;
                waddr_reg <= {awaddr[7:2], 2'h0};
            end
            if (wvalid && wready_reg)
            begin
                w_got_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (do_write)
            begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? isf_pkg::RESP_OKAY : isf_pkg::RESP_SLVERR;
            end
            else if (bready)
                bvalid_reg <= 1'b0;
        end
    end

    // Bus read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            raddr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= isf_pkg::RESP_OKAY;
        end
        else
        begin
            arready_reg <= arvalid && !arready_reg && !rd_pend_reg && !rvalid_reg;
            if (arvalid && arready_reg)
            begin
                raddr_reg <= {araddr[7:2], 2'h0};
                rd_pend_reg <= 1'b1;
            end
            if (rd_pend_reg)
            begin
                rd_pend_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? isf_pkg::RESP_OKAY : isf_pkg::RESP_SLVERR;
            end
            else if (rready)
                rvalid_reg <= 1'b0;
        end
    end

    // Registers and operation result
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= isf_pkg::CTRL_RESET;
            en_reg <= '0;
            stat_reg <= '0;
            irq_reg <= 1'b0;
            kind_reg <= isf_pkg::KIND_CONTROLLER_WRITE;
            prog_reg <= isf_pkg::PROG_IDLE_CODE;
            cause_reg <= isf_pkg::CAUSE_ADDRESS_REFUSED;
            flush_pend_reg <= 1'b0;
            low_q_reg <= 1'b0;
            empty_q_reg <= 1'b0;
            scl_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= strb_merge(ctrl_reg, wdata_reg, wstrb_reg) & isf_pkg::CTRL_MASK;
            if (wr_en)
                en_reg <= wdata_reg[isf_pkg::IRQ_W-1:0];
            stat_reg <= stat_next;
            irq_reg <= |(stat_next & (wr_en ? wdata_reg[isf_pkg::IRQ_W-1:0] : en_reg));
            flush_pend_reg <= tgt_read_req;
            low_q_reg <= low_lvl;
            empty_q_reg <= empty_lvl;
            scl_reg <= empty_lvl;
            if (tgt_read_req)
            begin
                kind_reg <= isf_pkg::KIND_TARGET_TRANSMIT;
                prog_reg <= isf_pkg::PROG_IN_PROGRESS;
                cause_reg <= isf_pkg::CAUSE_ADDRESS_REFUSED;
            end
            else if (op_start)
            begin
                kind_reg <= op_kind;
                prog_reg <= isf_pkg::PROG_IN_PROGRESS;
                cause_reg <= isf_pkg::CAUSE_ADDRESS_REFUSED;
            end
            else if (ab_any)
            begin
                prog_reg <= isf_pkg::PROG_ABORT;
                cause_reg <= abort_cause(misplaced_start_error, misplaced_stop_error,
                                         ctl_op && arbitration_defeat,
                                         ctl_op && address_refused);
            end
            else if (ok_ev)
                prog_reg <= isf_pkg::PROG_OK;
        end
    end

    // DMA request sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_state_reg <= isf_pkg::D_IDLE;
            final_pend_reg <= 1'b0;
            single_reg <= 1'b0;
            burst_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            if (dma_mode && tt_done)
                final_pend_reg <= 1'b1;
            unique case (dma_state_reg)
                isf_pkg::D_IDLE:
                begin
                    if (dma_go)
                    begin
                        burst_reg <= pick_burst;
                        single_reg <= !pick_burst;
                        last_reg <= final_pend_reg || tt_done;
                        final_pend_reg <= 1'b0;
                        dma_state_reg <= isf_pkg::D_WAIT;
                    end
                end
                isf_pkg::D_WAIT:
                begin
                    if (dma_served)
                    begin
                        burst_reg <= 1'b0;
                        single_reg <= 1'b0;
                        last_reg <= 1'b0;
                        dma_state_reg <= isf_pkg::D_IDLE;
                    end
                end
            endcase
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign tx_byte = fifo_data;
    assign tx_byte_valid = fifo_valid;
    assign scl_hold_low = scl_reg;
    assign dma_single_req = single_reg;
    assign dma_burst_req = burst_reg;
    assign dma_last = last_reg;
    assign irq = irq_reg;

    // Checks
    sequence s_flush_then_flag;
        flush_pend_reg ##1 stat_reg[isf_pkg::IRQ_RD_REQ];
    endsequence
    property p_low_flag;
        @(posedge aclk) disable iff (!aresetn)
        low_lvl && !low_q_reg |=> stat_reg[isf_pkg::IRQ_TX_LOW];
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low flag missed");
    property p_dma_pick;
        @(posedge aclk) disable iff (!aresetn)
        dma_state_reg == isf_pkg::D_IDLE && dma_mode && tt_active && fill_room
        |=> (burst_reg == $past(pick_burst)) && (single_reg != burst_reg);
    endproperty
    a_dma_pick: assert property (p_dma_pick) else $error("wrong dma request");
    property p_final;
        @(posedge aclk) disable iff (!aresetn)
        dma_mode && tt_done && dma_state_reg == isf_pkg::D_IDLE
        |=> last_reg && (single_reg || burst_reg);
    endproperty
    a_final: assert property (p_final) else $error("final dma request missing");
    property p_tt_record;
        @(posedge aclk) disable iff (!aresetn)
        tt_done && !op_start && !tgt_read_req
        |=> prog_reg == isf_pkg::PROG_OK && kind_reg == isf_pkg::KIND_TARGET_TRANSMIT
            && stat_reg[isf_pkg::IRQ_TGT_DONE];
    endproperty
    a_tt_record: assert property (p_tt_record) else $error("target done not recorded");
    property p_kind;
        @(posedge aclk) disable iff (!aresetn)
        op_start && !tgt_read_req |=> kind_reg == $past(op_kind);
    endproperty
    a_kind: assert property (p_kind) else $error("kind not recorded");
    property p_cause_idle;
        @(posedge aclk) disable iff (!aresetn)
        prog_reg != isf_pkg::PROG_ABORT |-> cause_reg == isf_pkg::CAUSE_ADDRESS_REFUSED;
    endproperty
    a_cause_idle: assert property (p_cause_idle) else $error("stale cause");
    property p_start_err;
        @(posedge aclk) disable iff (!aresetn)
        busy && misplaced_start_error && !op_start && !tgt_read_req
        |=> prog_reg == isf_pkg::PROG_ABORT && cause_reg == isf_pkg::CAUSE_MISPLACED_START_ERROR;
    endproperty
    a_start_err: assert property (p_start_err) else $error("start error cause");
    property p_arb;
        @(posedge aclk) disable iff (!aresetn)
        busy && ctl_op && arbitration_defeat && !misplaced_start_error
        && !misplaced_stop_error && !op_start && !tgt_read_req
        |=> cause_reg == isf_pkg::CAUSE_ARBITRATION_DEFEAT;
    endproperty
    a_arb: assert property (p_arb) else $error("arbitration cause");
    property p_flush;
        @(posedge aclk) disable iff (!aresetn)
        tgt_read_req |=> !tx_byte_valid ##0 s_flush_then_flag;
    endproperty
    a_flush: assert property (p_flush) else $error("flush before request flag");
    property p_same_cycle;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && $past(prog_reg) == isf_pkg::PROG_IN_PROGRESS
        && prog_reg != isf_pkg::PROG_IN_PROGRESS
        && !$past(op_start) && !$past(tgt_read_req)
        |-> stat_reg[isf_pkg::IRQ_OP_DONE] || stat_reg[isf_pkg::IRQ_OP_ABORT];
    endproperty
    a_same_cycle: assert property (p_same_cycle) else $error("progress ahead of flag");
endmodule : isf_top

// file: rtl/isf_txfifo.sv
`timescale 1ns/10ps
module isf_txfifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int CNT_W = $clog2(DEPTH + 2)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic flush,
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_ready,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    output logic [CNT_W-1:0] free_count
);
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("isf_txfifo DEPTH must be a power of two of at least 2");
        end
    endgenerate
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    wire push = wr_valid && wr_ready;
    wire load = cnt_reg != '0 && (!out_valid_reg || rd_ready);
    assign wr_ready = cnt_reg < CNT_W'(DEPTH);
    assign rd_valid = out_valid_reg;
    assign rd_data = out_data_reg;
    assign free_count = CNT_W'(DEPTH) - cnt_reg;

    always_ff @(posedge aclk)
    begin
        if (push)
            mem[wr_ptr_reg] <= wr_data;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            if (load)
            begin
                rd_ptr_reg <= rd_ptr_reg + PW'(1);
                out_data_reg <= mem[rd_ptr_reg];
                out_valid_reg <= 1'b1;
            end
            else if (rd_ready)
                out_valid_reg <= 1'b0;
            cnt_reg <= cnt_reg + CNT_W'(push) - CNT_W'(load);
        end
    end
endmodule : isf_txfifo

// file: verification/isf_engine_model.sv
`timescale 1ns/10ps
module isf_engine_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_byte_valid,
    input wire logic dma_req,
    output logic tx_take,
    output logic dma_served
);
    logic [1:0] wait_reg;
    assign tx_take = tx_byte_valid; // Takes each offered byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !dma_req || dma_served)
        begin
            wait_reg <= 2'h0;
            dma_served <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_reg + 2'h1;
            dma_served <= (wait_reg == 2'h2); // Slow service
        end
    end
endmodule : isf_engine_model

// file: verification/isf_top_bench.sv
`timescale 1ns/10ps
module isf_top_bench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, tx_byte;
    logic [31:0] wdata = 0, rdata, rd_d;
    logic [1:0] bresp, rresp, rd_r, wr_r, kd = 0;
    logic [8:0] ev = 0;
    logic awready, wready, bvalid, arready, rvalid, tx_take, dma_served, tx_byte_valid;
    logic scl_hold_low, dma_single_req, dma_burst_req, dma_last, irq, saw_b = 0, saw_l = 0;
    logic saw_s = 0;
    int num_errors = 0, samples_checked = 0;
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        saw_b |= dma_burst_req;
        saw_l |= dma_last;
        saw_s |= dma_single_req;
    end
    isf_top i_isf_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .op_start(ev[0]), .op_kind(kd), .op_ok(ev[1]), .address_refused(ev[2]),
        .data_refused(ev[3]), .arbitration_defeat(ev[4]), .misplaced_start_error(ev[5]),
        .misplaced_stop_error(ev[6]), .tgt_read_req(ev[7]), .tgt_nack_end(ev[8]),
        .tx_take(tx_take), .dma_served(dma_served), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .scl_hold_low(scl_hold_low),
        .dma_single_req(dma_single_req), .dma_burst_req(dma_burst_req), .dma_last(dma_last),
        .irq(irq));
    isf_engine_model i_isf_engine_model (.aclk(aclk), .aresetn(aresetn),
        .tx_byte_valid(tx_byte_valid), .dma_req(dma_single_req | dma_burst_req),
        .tx_take(tx_take), .dma_served(dma_served));
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 0;
            end
        join
        while (!bvalid) @(posedge aclk);
        wr_r = bresp;
        bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rd_d = rdata;
        rd_r = rresp;
        rready <= 0;
    endtask : rd
    task pl(input int i, input logic [1:0] k);
        @(posedge aclk);
        kd <= k;
        ev[i] <= 1;
        @(posedge aclk);
        ev <= 0;
    endtask : pl
    task t_regs;
        rd(8'h14);
        chk("result", 0, rd_d);
        rd(8'h1c);
        chk("rresp", isf_pkg::RESP_SLVERR, rd_r);
        wr(8'h1c, 32'h1);
        chk("bresp", isf_pkg::RESP_SLVERR, wr_r);
    endtask : t_regs
    task t_abort;
        logic [2:0] cz[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
        wr(8'h0c, 32'h20);
        for (int i = 0; i < 5; i++)
        begin
            pl(0, 0);
            rd(8'h14);
            chk("busy", 32'h4, rd_d);
            pl(i + 2, 0);
            rd(8'h14);
            chk("cause", {cz[i], 4'hc}, rd_d);
            chk("irq", 1, irq);
            wr(8'h08, 32'h3f);
            rd(8'h04);
            chk("irq_off", 0, irq);
        end
    endtask : t_abort
    task t_ok;
        pl(0, 1);
        pl(1, 1);
        rd(8'h14);
        chk("ok", 32'h9, rd_d);
    endtask : t_ok
    task t_target;
        pl(7, 3);
        repeat (4) @(posedge aclk);
        chk("hold", 1, scl_hold_low);
        rd(8'h04);
        chk("rdreq", 2, rd_d & 2);
        wr(8'h10, 32'ha5);
        @(posedge aclk);
        chk("byte", 32'h1a5, {tx_byte_valid, tx_byte});
        pl(8, 0);
        rd(8'h14);
        chk("tgt", 32'hb, rd_d);
        rd(8'h04);
        chk("done", 8, rd_d & 8);
        chk("low", 1, rd_d & 1);
    endtask : t_target
    task t_dma;
        wr(8'h00, 32'h41);
        pl(7, 3);
        repeat (20) @(posedge aclk);
        chk("burst", 1, saw_b);
        pl(8, 0);
        repeat (20) @(posedge aclk);
        chk("last", 1, saw_l);
        wr(8'h00, 32'h91);
        pl(7, 3);
        repeat (20) @(posedge aclk);
        chk("single", 1, saw_s);
        pl(8, 0);
        repeat (20) @(posedge aclk);
    endtask : t_dma
    task stop_test;
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        stop_test();
    end
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        t_regs(); t_abort(); t_ok(); t_target(); t_dma();
        stop_test();
    end
endmodule : isf_top_bench
